//--- design/dms_data_memory.sv
// Data memory with special function registers, indirect port and flags
`timescale 1ns/1ps
`default_nettype none
module dms_data_memory #(
	parameter int GP_DEPTH = dms_pkg::GP_DEPTH
) (
	// Clock and reset
	input wire logic clock,
	input wire logic rst,
	// Read port
	input wire logic rdEn,
	input wire logic [6:0] rdAddr,
	output logic [7:0] rdData,
	output logic rdValid,
	// Write port, mask selects bits
	input wire logic wrEn,
	input wire logic [6:0] wrAddr,
	input wire logic [7:0] wrData,
	input wire logic [7:0] wrMask,
	// Program counter from core
	input wire logic [10:0] pcIn,
	// Table read
	input wire logic tblRdEn,
	input wire logic tblLast,
	input wire logic pageOptEn,
	output logic tblReq,
	output logic [10:0] tblAddr,
	input wire logic tblWrEn,
	input wire logic [13:0] tblWord,
	input wire logic [6:0] tblDest,
	// Jump on low counter byte write
	output logic jumpPulse,
	output logic [10:0] jumpAddr,
	output logic dummyCycle,
	// Flag update from the core
	input wire logic aluEn,
	input wire dms_pkg::dms_alu_op_e aluOp,
	input wire logic [7:0] aluA,
	input wire logic [7:0] aluB,
	input wire logic [7:0] aluResult,
	// System events
	input wire logic sleepExec,
	input wire logic wdtRestart,
	input wire logic wdtTimeout,
	input wire logic irqEntry,
	input wire logic irqReturn,
	// Timer hardware load
	input wire logic tmrLoadEn,
	input wire logic [15:0] tmrLoadVal,
	// Register views
	output logic [7:0] workValue,
	output logic [7:0] flagValue,
	output logic [7:0] irqControl,
	output logic [15:0] timerCount,
	output logic [7:0] timerControl
);

	localparam logic [7:0] GP_END = {1'b0, dms_pkg::GP_BASE} + 8'(GP_DEPTH);
	localparam int GP_AW = $clog2(GP_DEPTH);

	logic [6:0] memPtr;
	logic [7:0] tabPtr;
	logic [7:0] tabHigh;
	logic [7:0] tabPage;
	logic [7:0] next_flag;
	logic [7:0] next_irq;

	// Write source: table destination takes the port over
	logic [6:0] wA;
	logic [7:0] wD;
	logic [7:0] wM;
	logic wReq;
	logic [6:0] wEff;
	logic wGo;
	logic wGp;

	// Merge masked data into an old byte
	function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] d,
		input logic [7:0] m);
		merge = (old & ~m) | (d & m);
	endfunction

	// Select write source and resolve indirection
	always_comb begin
		wA = tblWrEn ? tblDest : wrAddr;
		wD = tblWrEn ? tblWord[7:0] : wrData;
		wM = tblWrEn ? 8'hff : wrMask;
		wReq = tblWrEn | wrEn;
		wEff = (wA == dms_pkg::ADDR_INDIRECT) ? memPtr : wA;
		wGo = wReq && (wEff != dms_pkg::ADDR_INDIRECT);
		wGp = ({1'b0, wEff} >= {1'b0, dms_pkg::GP_BASE}) && ({1'b0, wEff} < GP_END);
	end

	// Read side address resolution
	logic [6:0] rEff;
	logic rGp;
	logic [7:0] sfrMux;
	logic rdV1;
	logic gp1;
	logic [7:0] sfr1;
	logic [7:0] gpData;

	always_comb begin
		rEff = (rdAddr == dms_pkg::ADDR_INDIRECT) ? memPtr : rdAddr;
		rGp = ({1'b0, rEff} >= {1'b0, dms_pkg::GP_BASE}) && ({1'b0, rEff} < GP_END);
	end

	// Special register read mux; unused and reserved read zero
	always_comb begin
		case (rEff)
			dms_pkg::ADDR_INDIRECT: sfrMux = 8'h00;
			dms_pkg::ADDR_MEM_PTR: sfrMux = {1'b1, memPtr};
			dms_pkg::ADDR_WORK: sfrMux = workValue;
			dms_pkg::ADDR_PC_LOW: sfrMux = pcIn[7:0];
			dms_pkg::ADDR_TAB_PTR: sfrMux = tabPtr;
			dms_pkg::ADDR_TAB_HIGH: sfrMux = tabHigh;
			dms_pkg::ADDR_FLAGS: sfrMux = flagValue;
			dms_pkg::ADDR_IRQ_CTL: sfrMux = irqControl;
			dms_pkg::ADDR_TIM_HIGH: sfrMux = timerCount[15:8];
			dms_pkg::ADDR_TIM_LOW: sfrMux = timerCount[7:0];
			dms_pkg::ADDR_TIM_CTL: sfrMux = timerControl;
			dms_pkg::ADDR_TAB_PAGE: sfrMux = tabPage;
			default: sfrMux = 8'h00;
		endcase
	end

	// General purpose area after the special registers
	dms_gp_ram #(
		.DW(8),
		.AW(GP_AW),
		.DEPTH(GP_DEPTH)
	) u_gp_ram (
		.clock(clock),
		.rst(rst),
		.wrEn(wGo && wGp),
		.wrAddr(GP_AW'(wEff - dms_pkg::GP_BASE)),
		.wrData(wD),
		.wrMask(wM),
		.rdAddr(GP_AW'(rEff - dms_pkg::GP_BASE)),
		.rdData(gpData)
	);

	// Two-stage read: whole old value captured in one edge
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			rdV1 <= 1'b0;
			gp1 <= 1'b0;
			sfr1 <= dms_pkg::RST_BYTE;
		end else begin
			rdV1 <= rdEn;
			gp1 <= rGp;
			sfr1 <= sfrMux;
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			rdData <= dms_pkg::RST_BYTE;
			rdValid <= 1'b0;
		end else begin
			rdValid <= rdV1;
			rdData <= gp1 ? gpData : sfr1;
		end
	end

	// Memory pointer: seven bits stored, top bit has no flop
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			memPtr <= dms_pkg::RST_PTR;
		end else if (wGo && wEff == dms_pkg::ADDR_MEM_PTR) begin
			memPtr <= (memPtr & ~wM[6:0]) | (wD[6:0] & wM[6:0]);
		end
	end

	// Work register and table pointer/page
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			workValue <= dms_pkg::RST_BYTE;
			tabPtr <= dms_pkg::RST_BYTE;
			tabPage <= dms_pkg::RST_BYTE;
		end else if (wGo) begin
			if (wEff == dms_pkg::ADDR_WORK) workValue <= merge(workValue, wD, wM);
			if (wEff == dms_pkg::ADDR_TAB_PTR) tabPtr <= merge(tabPtr, wD, wM);
			if (wEff == dms_pkg::ADDR_TAB_PAGE) tabPage <= merge(tabPage, wD, wM);
		end
	end

	// Table high byte: writes by address are ignored
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			tabHigh <= dms_pkg::RST_BYTE;
		end else if (tblWrEn) begin
			tabHigh <= {2'b00, tblWord[13:8]};
		end
	end

	// Table address: pointer for low bits, page source by mode
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			tblReq <= 1'b0;
			tblAddr <= dms_pkg::RST_PADDR;
		end else begin
			tblReq <= tblRdEn;
			if (tblRdEn) begin
				if (tblLast) begin
					tblAddr <= {dms_pkg::LAST_PAGE, tabPtr};
				end else if (pageOptEn) begin
					tblAddr <= {tabPage[2:0], tabPtr};
				end else begin
					tblAddr <= {pcIn[10:8], tabPtr};
				end
			end
		end
	end

	// Low counter byte write becomes an in-page jump plus a dummy cycle
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			jumpPulse <= 1'b0;
			jumpAddr <= dms_pkg::RST_PADDR;
			dummyCycle <= 1'b0;
		end else begin
			jumpPulse <= wGo && (wEff == dms_pkg::ADDR_PC_LOW) && (wM != 8'h00);
			dummyCycle <= jumpPulse;
			if (wGo && wEff == dms_pkg::ADDR_PC_LOW) begin
				jumpAddr <= {pcIn[10:8], merge(pcIn[7:0], wD, wM)};
			end
		end
	end

	// Flag arithmetic on the operands the core reports
	logic cin;
	logic sub;
	logic [7:0] bOp;
	logic [8:0] sum9;
	logic [4:0] low5;
	logic [7:0] low8;

	always_comb begin
		sub = (aluOp == dms_pkg::ALU_SUB) || (aluOp == dms_pkg::ALU_SBC);
		case (aluOp)
			dms_pkg::ALU_ADC: cin = flagValue[dms_pkg::FLAG_CARRY];
			dms_pkg::ALU_SBC: cin = flagValue[dms_pkg::FLAG_CARRY];
			dms_pkg::ALU_SUB: cin = 1'b1;
			default: cin = 1'b0;
		endcase
		// Subtract as add of complement: carry out means no borrow
		bOp = sub ? ~aluB : aluB;
		sum9 = {1'b0, aluA} + {1'b0, bOp} + {8'h00, cin};
		low5 = {1'b0, aluA[3:0]} + {1'b0, bOp[3:0]} + {4'h0, cin};
		low8 = {1'b0, aluA[6:0]} + {1'b0, bOp[6:0]} + {7'h00, cin};
	end

	// Next flag value: write, then operation, then system events
	always_comb begin
		next_flag = flagValue;
		if (wGo && wEff == dms_pkg::ADDR_FLAGS) begin
			next_flag = (merge(flagValue, wD, wM) & ~dms_pkg::FLAG_PROTECT)
				| (flagValue & dms_pkg::FLAG_PROTECT);
		end
		if (aluEn) begin
			case (aluOp)
				dms_pkg::ALU_ADD, dms_pkg::ALU_ADC, dms_pkg::ALU_SUB, dms_pkg::ALU_SBC: begin
					next_flag[dms_pkg::FLAG_CARRY] = sum9[8];
					next_flag[dms_pkg::FLAG_HALF] = low5[4];
					next_flag[dms_pkg::FLAG_ZERO] = (sum9[7:0] == 8'h00);
					next_flag[dms_pkg::FLAG_WRAP] = low8[7] ^ sum9[8];
				end
				dms_pkg::ALU_LOGIC: next_flag[dms_pkg::FLAG_ZERO] = (aluResult == 8'h00);
				dms_pkg::ALU_RRC: next_flag[dms_pkg::FLAG_CARRY] = aluA[0];
				dms_pkg::ALU_RLC: next_flag[dms_pkg::FLAG_CARRY] = aluA[7];
				default: next_flag = next_flag;
			endcase
		end
		if (wdtRestart) begin
			next_flag[dms_pkg::FLAG_SLEEP] = 1'b0;
			next_flag[dms_pkg::FLAG_WDOG] = 1'b0;
		end
		if (sleepExec) begin
			next_flag[dms_pkg::FLAG_SLEEP] = 1'b1;
			next_flag[dms_pkg::FLAG_WDOG] = 1'b0;
		end
		// Time-out set beats any clear in the same cycle
		if (wdtTimeout) next_flag[dms_pkg::FLAG_WDOG] = 1'b1;
	end

	// Flags are plain state; nothing pushes them on call or entry
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			flagValue <= dms_pkg::RST_BYTE;
		end else begin
			flagValue <= next_flag;
		end
	end

	// Interrupt control: return sets global enable over any clear
	always_comb begin
		next_irq = irqControl;
		if (wGo && wEff == dms_pkg::ADDR_IRQ_CTL) next_irq = merge(irqControl, wD, wM);
		if (irqEntry) next_irq[dms_pkg::IRQ_GLOBAL] = 1'b0;
		if (irqReturn) next_irq[dms_pkg::IRQ_GLOBAL] = 1'b1;
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			irqControl <= dms_pkg::RST_BYTE;
		end else begin
			irqControl <= next_irq;
		end
	end

	// Timer pair: hardware load first, software preload overrides a byte
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			timerCount <= dms_pkg::RST_COUNT;
		end else begin
			if (tmrLoadEn) timerCount <= tmrLoadVal;
			if (wGo && wEff == dms_pkg::ADDR_TIM_HIGH) begin
				timerCount[15:8] <= merge(timerCount[15:8], wD, wM);
			end
			if (wGo && wEff == dms_pkg::ADDR_TIM_LOW) begin
				timerCount[7:0] <= merge(timerCount[7:0], wD, wM);
			end
		end
	end

	// Timer control: mode in top bits, run bit below
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			timerControl <= dms_pkg::RST_BYTE;
		end else if (wGo && wEff == dms_pkg::ADDR_TIM_CTL) begin
			timerControl <= merge(timerControl, wD, wM);
		end
	end

	// Checks
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	property p_ptr_top;
		rdEn && rdAddr == dms_pkg::ADDR_MEM_PTR |-> ##2 rdValid && rdData[7];
	endproperty
	a_ptr_top: assert property (p_ptr_top) else $error("pointer top bit not one");

	property p_null_read;
		rdEn && rdAddr == dms_pkg::ADDR_INDIRECT && memPtr == dms_pkg::ADDR_INDIRECT
			|-> ##2 rdData == 8'h00;
	endproperty
	a_null_read: assert property (p_null_read) else $error("self-indirect read not zero");

	property p_gap_zero;
		rdEn && rdAddr == 7'h02 |-> ##2 rdValid && rdData == 8'h00;
	endproperty
	a_gap_zero: assert property (p_gap_zero) else $error("unused location not zero");

	property p_jump;
		wrEn && !tblWrEn && wrAddr == dms_pkg::ADDR_PC_LOW && wrMask == 8'hff
			|=> jumpPulse && jumpAddr == {$past(pcIn[10:8]), $past(wrData)} ##1 dummyCycle;
	endproperty
	a_jump: assert property (p_jump) else $error("low byte write did not jump");

	property p_last_page;
		tblRdEn && tblLast |=> tblReq && tblAddr == {dms_pkg::LAST_PAGE, $past(tabPtr)};
	endproperty
	a_last_page: assert property (p_last_page) else $error("last page address wrong");

	property p_tab_high_ro;
		!tblWrEn |=> $stable(tabHigh);
	endproperty
	a_tab_high_ro: assert property (p_tab_high_ro) else $error("table high byte changed");

	property p_protect;
		!sleepExec && !wdtRestart && !wdtTimeout
			|=> $stable(flagValue[dms_pkg::FLAG_WDOG:dms_pkg::FLAG_SLEEP]);
	endproperty
	a_protect: assert property (p_protect) else $error("protected flag changed");

	property p_sleep;
		sleepExec && !wdtTimeout |=> flagValue[dms_pkg::FLAG_SLEEP]
			&& !flagValue[dms_pkg::FLAG_WDOG];
	endproperty
	a_sleep: assert property (p_sleep) else $error("sleep flags wrong");

	property p_wdog;
		wdtTimeout |=> flagValue[dms_pkg::FLAG_WDOG];
	endproperty
	a_wdog: assert property (p_wdog) else $error("timeout flag not set");

	property p_irq_entry;
		irqEntry && !irqReturn |=> !irqControl[dms_pkg::IRQ_GLOBAL];
	endproperty
	a_irq_entry: assert property (p_irq_entry) else $error("global enable not cleared");

	property p_add_carry;
		aluEn && aluOp == dms_pkg::ALU_ADD
			|=> flagValue[dms_pkg::FLAG_CARRY] == (({1'b0, $past(aluA)} + {1'b0, $past(aluB)}) > 9'h0ff);
	endproperty
	a_add_carry: assert property (p_add_carry) else $error("add carry wrong");

endmodule
`default_nettype wire

//--- design/dms_pkg.sv
// Constants and types shared by the data memory and special register file
// Operation
// - Byte-wide data memory from zero, registers first
// - Unused and reserved locations read as zero
// - Address zero redirects through the memory pointer
// - Pointer at zero: read zero, write nothing
// - Pointer top bit absent, always reads one
// - Masked bit writes; protected and read-only bits
// - Low counter byte write jumps in-page, dummy cycle
// - Table read splits word into two bytes
// - Current-page table address from pointer and page
// - Last-page table read forces high bits one
// - Table high byte only loaded by table read
// - Flag writes never touch sleep or watchdog bits
// - Carry from add, no-borrow, or rotate
// - Half carry from low nibble carry
// - Zero flag follows result equal to zero
// - Signed wrap when carries into/out differ
// - Sleep flag: set by sleep, cleared by restart
// - Watchdog flag: set by timeout, cleared by restart or sleep
// - Flags never saved automatically on call or interrupt
// - Global enable cleared on entry, set on return
// - Sixteen-bit timer count in byte pair, preloadable
// - Timer control holds mode and run bit
package dms_pkg;

	// Data memory address width; top pointer bit has no storage
	localparam int DATA_AW = 7;
	localparam int PTR_TOP_BIT = 7;

	// Special register locations
	localparam logic [6:0] ADDR_INDIRECT = 7'h00;
	localparam logic [6:0] ADDR_MEM_PTR = 7'h01;
	localparam logic [6:0] ADDR_WORK = 7'h05;
	localparam logic [6:0] ADDR_PC_LOW = 7'h06;
	localparam logic [6:0] ADDR_TAB_PTR = 7'h07;
	localparam logic [6:0] ADDR_TAB_HIGH = 7'h08;
	localparam logic [6:0] ADDR_FLAGS = 7'h0a;
	localparam logic [6:0] ADDR_IRQ_CTL = 7'h0b;
	localparam logic [6:0] ADDR_TIM_HIGH = 7'h0c;
	localparam logic [6:0] ADDR_TIM_LOW = 7'h0d;
	localparam logic [6:0] ADDR_TIM_CTL = 7'h0e;
	localparam logic [6:0] ADDR_TAB_PAGE = 7'h1f;
	localparam logic [6:0] GP_BASE = 7'h20;
	localparam int GP_DEPTH = 32;

	// Flag register bit positions
	localparam int FLAG_CARRY = 0;
	localparam int FLAG_HALF = 1;
	localparam int FLAG_ZERO = 2;
	localparam int FLAG_WRAP = 3;
	localparam int FLAG_SLEEP = 4;
	localparam int FLAG_WDOG = 5;
	localparam logic [7:0] FLAG_PROTECT = 8'h30;

	// Interrupt control and timer control fields
	localparam int IRQ_GLOBAL = 0;
	localparam int TIM_RUN = 4;
	localparam int TIM_MODE_LO = 6;
	localparam int TIM_MODE_HI = 7;

	// Reset values
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [6:0] RST_PTR = 7'h00;
	localparam logic [15:0] RST_COUNT = 16'h0000;
	localparam logic [10:0] RST_PADDR = 11'h000;

	// Table page forced by the last-page read
	localparam logic [2:0] LAST_PAGE = 3'h7;

	// Cycles from read request to read data
	localparam int READ_LATENCY = 2;

	// Flag-affecting operation reported by the core
	typedef enum logic [2:0] {
		ALU_NONE,
		ALU_ADD,
		ALU_ADC,
		ALU_SUB,
		ALU_SBC,
		ALU_LOGIC,
		ALU_RRC,
		ALU_RLC
	} dms_alu_op_e;

endpackage

//--- design/dms_gp_ram.sv
// General purpose RAM with per-bit write mask and registered read
`timescale 1ns/1ps
`default_nettype none
module dms_gp_ram #(
	parameter int DW = 8,
	parameter int AW = 5,
	parameter int DEPTH = 32
) (
	// Clock and reset
	input wire logic clock,
	input wire logic rst,
	// Write side
	input wire logic wrEn,
	input wire logic [AW-1:0] wrAddr,
	input wire logic [DW-1:0] wrData,
	input wire logic [DW-1:0] wrMask,
	// Read side
	input wire logic [AW-1:0] rdAddr,
	output logic [DW-1:0] rdData
);

	logic [DW-1:0] mem [DEPTH];

	// Masked write keeps bits outside the mask
	always_ff @(posedge clock) begin
		if (wrEn) begin
			mem[wrAddr] <= (mem[wrAddr] & ~wrMask) | (wrData & wrMask);
		end
	end

	// Read before write: same-cycle read returns old word whole
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			rdData <= '0;
		end else begin
			rdData <= mem[rdAddr];
		end
	end

endmodule
`default_nettype wire

//--- verification/dms_core_model.sv
// Program memory side of the core: answers table fetches after a lag
`timescale 1ns/1ps
`default_nettype none
module dms_core_model (
	// Clock and reset
	input wire logic clock,
	input wire logic rst,
	// Fetch request and bench knobs
	input wire logic tblReq,
	input wire logic [10:0] tblAddr,
	input wire logic [3:0] lag,
	input wire logic [6:0] dest,
	// Fetched word back to the block
	output logic tblWrEn,
	output logic [13:0] tblWord,
	output logic [6:0] tblDest
);
	logic [3:0] cnt;
	logic [13:0] word;

	// Word built from its address so every fetch is distinct
	always @(posedge clock or posedge rst) begin
		if (rst) begin
			cnt <= 4'h0;
			word <= 14'h0000;
			tblWrEn <= 1'b0;
			tblWord <= 14'h2aaa;
			tblDest <= 7'h55;
		end else begin
			if (tblReq === 1'b1) begin
				word <= {tblAddr[10:5], tblAddr[7:0]};
				cnt <= lag;
			end else if (cnt != 4'h0) begin
				cnt <= cnt - 4'h1;
			end
			tblWrEn <= (cnt == 4'h1);
			// Idle bus keeps moving so stale data never looks valid
			tblWord <= (cnt == 4'h1) ? word : ~tblWord;
			tblDest <= (cnt == 4'h1) ? dest : ~tblDest;
		end
	end
endmodule
`default_nettype wire

//--- verification/tb_data_memory_sfr_file.sv
// Self-checking bench for the data memory and special register file
`timescale 1ns/1ps
`default_nettype none
module tb_data_memory_sfr_file;
	typedef struct {logic [6:0] a; logic [7:0] d; logic [7:0] m; logic [7:0] e;} dms_row_s;
	typedef struct {dms_pkg::dms_alu_op_e op; logic [7:0] a; logic [7:0] b; logic [7:0] r;
		logic [7:0] e;} dms_alu_s;
	logic clock = 0, rst = 1, rdEn = 0, rdValid, wrEn = 0, tblRdEn = 0, tblLast = 0;
	logic pageOptEn = 0, tblReq, tblWrEn, jumpPulse, dummyCycle, aluEn = 0, tmrLoadEn = 0;
	logic [6:0] rdAddr = 0, wrAddr = 0, tblDest, dest = 7'h31;
	logic [7:0] rdData, wrData = 0, wrMask = 0, aluA = 0, aluB = 0, aluResult = 0, q;
	logic [7:0] workValue, flagValue, irqControl, timerControl;
	logic [10:0] pcIn = 11'h5a3, tblAddr, jumpAddr;
	logic [13:0] tblWord;
	logic [15:0] tmrLoadVal = 0, timerCount;
	logic [4:0] evt = 0;
	logic [3:0] lag = 4'h1;
	dms_pkg::dms_alu_op_e aluOp = dms_pkg::ALU_NONE;
	int errors = 0, nTests = 0;
	dms_row_s rows[] = '{'{7'h01, 8'h25, 8'hff, 8'ha5}, '{7'h05, 8'hc3, 8'hff, 8'hc3},
		'{7'h07, 8'h46, 8'hff, 8'h46}, '{7'h1f, 8'h03, 8'hff, 8'h03}, '{7'h0b, 8'h01, 8'hff, 8'h01},
		'{7'h0c, 8'h12, 8'hff, 8'h12}, '{7'h0d, 8'h34, 8'hff, 8'h34}, '{7'h0e, 8'hd0, 8'hff, 8'hd0},
		'{7'h20, 8'h5a, 8'hff, 8'h5a}, '{7'h3f, 8'ha5, 8'hff, 8'ha5}, '{7'h3f, 8'hff, 8'h10, 8'hb5},
		'{7'h3f, 8'h00, 8'h01, 8'hb4}, '{7'h02, 8'hff, 8'hff, 8'h00}, '{7'h0f, 8'hff, 8'hff, 8'h00},
		'{7'h40, 8'hff, 8'hff, 8'h00}, '{7'h08, 8'hff, 8'hff, 8'h00}, '{7'h0a, 8'h3f, 8'hff, 8'h0f}};
	dms_alu_s alus[] = '{'{dms_pkg::ALU_ADD, 8'h0f, 8'h01, 8'h10, 8'h02},
		'{dms_pkg::ALU_ADD, 8'h80, 8'h80, 8'h00, 8'h0d}, '{dms_pkg::ALU_SUB, 8'h05, 8'h05, 8'h00, 8'h07},
		'{dms_pkg::ALU_LOGIC, 8'h00, 8'h00, 8'h01, 8'h03}, '{dms_pkg::ALU_RRC, 8'h00, 8'h00, 8'h00, 8'h02},
		'{dms_pkg::ALU_RLC, 8'h80, 8'h00, 8'h00, 8'h03}, '{dms_pkg::ALU_ADC, 8'hff, 8'h00, 8'h00, 8'h07},
		'{dms_pkg::ALU_SBC, 8'h00, 8'h00, 8'h00, 8'h07}, '{dms_pkg::ALU_NONE, 8'h00, 8'h00, 8'h00, 8'h07}};

	// Event pulses share one vector so a single task drives them all
	wire logic irqReturn = evt[4];
	wire logic irqEntry = evt[3];
	wire logic wdtTimeout = evt[2];
	wire logic wdtRestart = evt[1];
	wire logic sleepExec = evt[0];

	always #12.5 clock = ~clock;

	dms_data_memory i_dms_data_memory (.clock(clock), .rst(rst), .rdEn(rdEn), .rdAddr(rdAddr),
		.rdData(rdData), .rdValid(rdValid), .wrEn(wrEn), .wrAddr(wrAddr), .wrData(wrData),
		.wrMask(wrMask), .pcIn(pcIn), .tblRdEn(tblRdEn), .tblLast(tblLast), .pageOptEn(pageOptEn),
		.tblReq(tblReq), .tblAddr(tblAddr), .tblWrEn(tblWrEn), .tblWord(tblWord), .tblDest(tblDest),
		.jumpPulse(jumpPulse), .jumpAddr(jumpAddr), .dummyCycle(dummyCycle), .aluEn(aluEn),
		.aluOp(aluOp), .aluA(aluA), .aluB(aluB), .aluResult(aluResult), .sleepExec(sleepExec),
		.wdtRestart(wdtRestart), .wdtTimeout(wdtTimeout), .irqEntry(irqEntry),
		.irqReturn(irqReturn), .tmrLoadEn(tmrLoadEn), .tmrLoadVal(tmrLoadVal),
		.workValue(workValue), .flagValue(flagValue), .irqControl(irqControl),
		.timerCount(timerCount), .timerControl(timerControl));

	dms_core_model i_dms_core_model (.clock(clock), .rst(rst), .tblReq(tblReq), .tblAddr(tblAddr),
		.lag(lag), .dest(dest), .tblWrEn(tblWrEn), .tblWord(tblWord), .tblDest(tblDest));

	// Verdict and end of run
	task automatic results();
		$display("comparisons %0d mismatches %0d", nTests, errors);
		if (errors == 0 && nTests > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		nTests++;
		if (seen !== exp) begin
			errors++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// Byte or masked write; extra cycle keeps strobes from retriggering
	task automatic wr(input logic [6:0] a, input logic [7:0] d, input logic [7:0] m);
		wrEn = 1;
		wrAddr = a;
		wrData = d;
		wrMask = m;
		@(negedge clock);
		wrEn = 0;
		@(negedge clock);
	endtask

	// Read with a bounded wait for the valid pulse
	task automatic rd(input logic [6:0] a, output logic [7:0] r);
		int i;
		rdEn = 1;
		rdAddr = a;
		@(negedge clock);
		rdEn = 0;
		for (i = 0; i < 4 && rdValid !== 1'b1; i++) @(negedge clock);
		if (i == 4) begin
			errors++;
			results();
		end
		r = rdData;
	endtask

	// Table fetch in one mode, then both destination bytes read back
	task automatic tbl(input logic opt, input logic last, input logic [10:0] ea, input logic [3:0] lg,
		input logic [6:0] d);
		logic [7:0] r;
		int i;
		pageOptEn = opt;
		tblLast = last;
		lag = lg;
		dest = d;
		tblRdEn = 1;
		@(negedge clock);
		tblRdEn = 0;
		chk(tblReq, 16'h0001);
		chk(tblAddr, ea);
		for (i = 0; i < 20 && tblWrEn !== 1'b1; i++) @(negedge clock);
		if (i == 20) begin
			errors++;
			results();
		end
		@(negedge clock);
		rd(d, r);
		chk(r, ea[7:0]);
		rd(7'h08, r);
		chk(r, {2'b00, ea[10:5]});
	endtask

	// Event pulse, flags looked at in the cycle after
	task automatic ev(input logic [4:0] v, input logic [7:0] ef);
		evt = v;
		@(negedge clock);
		evt = 5'h00;
		chk(flagValue, ef);
		@(negedge clock);
	endtask

	initial begin
		repeat (10) @(negedge clock);
		rst = 0;
		chk({flagValue, irqControl}, 16'h0000);
		chk(timerCount, 16'h0000);
		foreach (rows[k]) begin
			wr(rows[k].a, rows[k].d, rows[k].m);
			rd(rows[k].a, q);
			chk(q, rows[k].e);
		end
		chk(timerCount, 16'h1234);
		chk(timerControl, 16'h00d0);
		$display("register map test done");
		wr(7'h01, 8'h22, 8'hff);
		wr(7'h00, 8'h77, 8'hff);
		rd(7'h22, q);
		chk(q, 8'h77);
		rd(7'h00, q);
		chk(q, 8'h77);
		wr(7'h01, 8'h00, 8'hff);
		wr(7'h00, 8'h99, 8'hff);
		rd(7'h00, q);
		chk(q, 8'h00);
		rd(7'h01, q);
		chk(q, 8'h80);
		$display("indirect test done");
		wrEn = 1;
		wrAddr = 7'h06;
		wrData = 8'h3c;
		wrMask = 8'hff;
		@(negedge clock);
		wrEn = 0;
		chk({jumpPulse, jumpAddr}, 16'h0d3c);
		@(negedge clock);
		chk({dummyCycle, jumpPulse}, 16'h0002);
		$display("jump test done");
		tbl(1'b0, 1'b0, 11'h546, 4'h1, 7'h31);
		tbl(1'b1, 1'b0, 11'h346, 4'h2, 7'h32);
		tbl(1'b1, 1'b1, 11'h746, 4'h6, 7'h33);
		$display("table read test done");
		aluEn = 1;
		foreach (alus[k]) begin
			aluOp = alus[k].op;
			aluA = alus[k].a;
			aluB = alus[k].b;
			aluResult = alus[k].r;
			@(negedge clock);
			chk(flagValue, alus[k].e);
		end
		aluEn = 0;
		$display("flag arithmetic test done");
		ev(5'h04, 8'h27);
		ev(5'h01, 8'h17);
		ev(5'h04, 8'h37);
		wr(7'h0a, 8'h00, 8'hff);
		rd(7'h0a, q);
		chk(q, 8'h30);
		ev(5'h08, 8'h30);
		chk(irqControl[0], 16'h0000);
		ev(5'h10, 8'h30);
		chk(irqControl[0], 16'h0001);
		ev(5'h02, 8'h00);
		$display("event test done");
		tmrLoadEn = 1;
		tmrLoadVal = 16'hbeef;
		@(negedge clock);
		tmrLoadEn = 0;
		chk(timerCount, 16'hbeef);
		rd(7'h0d, q);
		chk(q, 8'hef);
		$display("timer load test done");
		// Same-cycle write and read: read must see the whole old byte
		wrEn = 1;
		rdEn = 1;
		wrAddr = 7'h05;
		rdAddr = 7'h05;
		wrData = 8'h5c;
		wrMask = 8'hff;
		@(negedge clock);
		wrEn = 0;
		rdEn = 0;
		@(negedge clock);
		chk({rdValid, rdData}, 16'h01c3);
		chk(workValue, 16'h005c);
		// Mid-run reset clears registers; first read on first edge after
		rst = 1;
		@(negedge clock);
		chk({flagValue, irqControl}, 16'h0000);
		chk({workValue, timerControl}, 16'h0000);
		chk(timerCount, 16'h0000);
		rst = 0;
		rd(7'h01, q);
		chk(q, 8'h80);
		rd(7'h08, q);
		chk(q, 8'h00);
		$display("reset test done");
		results();
	end
endmodule
`default_nettype wire
